// File: logic/dma_flag_pkg.sv
// Shared constants and carrier types for the DMA event-flag clear block.
// Assumes a single 200 MHz system clock and a plain one-cycle register port.
package dma_flag_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned DEF_CH_NUM = 7;   // Channels served
  localparam int unsigned FLAG_W     = 4;   // Flags per channel
  localparam int unsigned ADDR_W     = 8;   // Register address width
  localparam int unsigned DATA_W     = 32;  // Register data width

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] FLAG_STAT_OFS = 8'h00;  // Flag status, read only
  localparam logic [ADDR_W-1:0] FLAG_CLR_OFS  = 8'h04;  // Flag clear, write only
  localparam logic [ADDR_W-1:0] IRQ_EN_OFS    = 8'h40;  // Interrupt enable, read/write

  // ----------------------------------------------------------------
  // Field positions inside one channel nibble
  // ----------------------------------------------------------------
  localparam int unsigned ERR_POS  = 3;  // Transfer error
  localparam int unsigned HALF_POS = 2;  // Half transfer
  localparam int unsigned DONE_POS = 1;  // Transfer complete
  localparam int unsigned GLOB_POS = 0;  // Global, any of the three

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] REG_RST_VAL  = 32'h0000_0000;
  localparam logic [FLAG_W-1:0] FLAG_RST_VAL = 4'h0;

  // Events raised by one channel's transfer engine
  typedef struct packed {
    logic err;   // Transfer error pulse
    logic half;  // Half transfer pulse
    logic done;  // Transfer complete pulse
  } chan_evt_s;

  // One register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;   // Byte address
    logic [DATA_W-1:0] wdata;  // Write data
    logic              wr;     // Write strobe
    logic              rd;     // Read strobe
  } reg_req_s;

endpackage

// File: logic/dma_chan_flags.sv
// Four sticky event flags of one DMA channel.
// Assumes event pulses and clear strobes come from logic on clk_sys.
`timescale 1ns/1ps

module dma_chan_flags
  import dma_flag_pkg::*;
(
  input  wire logic              clk_sys,  // System clock
  input  wire logic              nrst,     // Synchronous reset, active low
  input  wire chan_evt_s         evt,      // Event pulses this cycle
  input  wire logic [FLAG_W-1:0] clr,      // Clear strobes, channel nibble
  output logic      [FLAG_W-1:0] flags_q   // Sticky flags
);

  // ----------------------------------------------------------------
  // Next-state terms
  // ----------------------------------------------------------------
  logic              any_evt;   // Any event of this channel
  logic              clr_all;   // Global clear wipes all four
  logic [FLAG_W-1:0] flags_d;   // Next flags

  assign any_evt = evt.err | evt.half | evt.done;
  assign clr_all = clr[GLOB_POS];

  // set wins clear
  // An event in the clearing cycle must not be lost, so set has priority
  assign flags_d[ERR_POS]  = evt.err  | (flags_q[ERR_POS]  & ~(clr[ERR_POS]  | clr_all));
  assign flags_d[HALF_POS] = evt.half | (flags_q[HALF_POS] & ~(clr[HALF_POS] | clr_all));
  assign flags_d[DONE_POS] = evt.done | (flags_q[DONE_POS] & ~(clr[DONE_POS] | clr_all));
  assign flags_d[GLOB_POS] = any_evt  | (flags_q[GLOB_POS] & ~clr_all);

  // ----------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      flags_q <= FLAG_RST_VAL;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule

// File: logic/dma_flag_clear.sv
// DMA event flags with their write-one-to-clear register and interrupt.
// Assumes a register master on clk_sys and event pulses from the same clock.
`timescale 1ns/1ps

module dma_flag_clear
  import dma_flag_pkg::*;
#(
  parameter int unsigned CH_NUM = DEF_CH_NUM  // Number of channels
)
(
  input  wire logic                     clk_sys,      // System clock, 200 MHz
  input  wire logic                     nrst,         // Synchronous reset, active low
  input  wire reg_req_s                 reg_req,      // Register request
  input  wire chan_evt_s [CH_NUM-1:0]   chan_evt,     // Per-channel event pulses
  output logic      [DATA_W-1:0]        rd_data_q,    // Read data, cycle after read
  output logic      [FLAG_W*CH_NUM-1:0] flag_stat_q,  // Sticky flags, all channels
  output logic      [FLAG_W*CH_NUM-1:0] clr_pulse_q,  // Registered clear strobes
  output logic                          irq_q         // Level interrupt
);

  localparam int unsigned FLAG_BITS = FLAG_W * CH_NUM;  // Used flag bits

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Every channel nibble must fit in one data word
  if (CH_NUM < 1 || FLAG_BITS > DATA_W) begin : g_bad_ch_num
    $error("CH_NUM does not fit the register word");
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic hit_stat;  // Address selects flag status
  logic hit_clr;   // Address selects flag clear
  logic hit_en;    // Address selects interrupt enable
  logic clr_wr;    // Write to the clear register
  logic en_wr;     // Write to the enable register

  assign hit_stat = (reg_req.addr == FLAG_STAT_OFS);
  assign hit_clr  = (reg_req.addr == FLAG_CLR_OFS);
  assign hit_en   = (reg_req.addr == IRQ_EN_OFS);
  assign clr_wr   = reg_req.wr & hit_clr;
  assign en_wr    = reg_req.wr & hit_en;

  // ----------------------------------------------------------------
  // Clear strobes
  // ----------------------------------------------------------------
  logic [FLAG_BITS-1:0] clr_vec;  // Strobes live only in the write cycle

  // stateless clear strobe
  // Nothing is stored: the write data act for exactly the write cycle,
  // and bits above the channel field never reach any flag
  assign clr_vec = clr_wr ? reg_req.wdata[FLAG_BITS-1:0] : '0;

  // ----------------------------------------------------------------
  // Per-channel flag cells
  // ----------------------------------------------------------------
  // one nibble per channel
  // channels 7 to 1
  // Channel n takes nibble n-1: error, half, complete, global from high to low
  for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_chan
    dma_chan_flags u_flags (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .evt     (chan_evt[ch]),
      .clr     (clr_vec[FLAG_W*ch +: FLAG_W]),
      .flags_q (flag_stat_q[FLAG_W*ch +: FLAG_W])
    );
  end

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------
  logic [FLAG_BITS-1:0] irq_en_q;  // One enable per flag

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_en_q <= REG_RST_VAL[FLAG_BITS-1:0];
    end else if (en_wr) begin
      irq_en_q <= reg_req.wdata[FLAG_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt output
  // ----------------------------------------------------------------
  logic irq_d;  // Any enabled flag set

  // Follows the flags one cycle late; the trade keeps the pin glitch free
  assign irq_d = |(flag_stat_q & irq_en_q);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Registered clear strobes toward the flag consumers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      clr_pulse_q <= REG_RST_VAL[FLAG_BITS-1:0];
    end else begin
      clr_pulse_q <= clr_vec;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] stat_word;  // Flags zero extended
  logic [DATA_W-1:0] en_word;    // Enables zero extended
  logic [DATA_W-1:0] rd_data_d;  // Selected read word

  assign stat_word = {{(DATA_W-FLAG_BITS){1'b0}}, flag_stat_q};
  assign en_word   = {{(DATA_W-FLAG_BITS){1'b0}}, irq_en_q};
  // Clear register and unmapped addresses read as zero
  assign rd_data_d = !reg_req.rd ? REG_RST_VAL :
                     hit_stat    ? stat_word   :
                     hit_en      ? en_word     : REG_RST_VAL;

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      rd_data_q <= REG_RST_VAL;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int unsigned TOP = FLAG_W * (CH_NUM - 1);  // Last channel nibble base

  a_last_err_clear:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (clr_wr && reg_req.wdata[TOP+ERR_POS] && !chan_evt[CH_NUM-1].err)
      |=> !flag_stat_q[TOP+ERR_POS])
    else $error("error flag not cleared by write of one");

  a_last_half_clear:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (clr_wr && reg_req.wdata[TOP+HALF_POS] && !chan_evt[CH_NUM-1].half)
      |=> !flag_stat_q[TOP+HALF_POS])
    else $error("half flag not cleared by write of one");

  a_last_done_clear:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (clr_wr && reg_req.wdata[TOP+DONE_POS] && !chan_evt[CH_NUM-1].done)
      |=> !flag_stat_q[TOP+DONE_POS])
    else $error("complete flag not cleared by write of one");

  a_last_all_clear:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (clr_wr && reg_req.wdata[TOP+GLOB_POS] && chan_evt[CH_NUM-1] == '0)
      |=> flag_stat_q[TOP +: FLAG_W] == '0)
    else $error("global clear left a flag set");

  for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_chk
    a_zero_keeps_err:
      assert property (@(posedge clk_sys) disable iff (!nrst)
        (clr_wr && flag_stat_q[FLAG_W*ch+ERR_POS]
         && !reg_req.wdata[FLAG_W*ch+ERR_POS] && !reg_req.wdata[FLAG_W*ch+GLOB_POS])
        |=> flag_stat_q[FLAG_W*ch+ERR_POS])
      else $error("error flag lost on write of zero");
    a_own_bit_clears:
      assert property (@(posedge clk_sys) disable iff (!nrst)
        (clr_wr && reg_req.wdata[FLAG_W*ch+DONE_POS] && !chan_evt[ch].done)
        |=> !flag_stat_q[FLAG_W*ch+DONE_POS])
      else $error("complete flag of a channel not cleared");

    a_err_flag_holds:
      assert property (@(posedge clk_sys) disable iff (!nrst)
        (flag_stat_q[FLAG_W*ch+ERR_POS] && !clr_vec[FLAG_W*ch+ERR_POS] && !clr_vec[FLAG_W*ch+GLOB_POS])
        |=> flag_stat_q[FLAG_W*ch+ERR_POS])
      else $error("error flag dropped without a clear");

    // no set without event
    // A cell that rises without an event would still pass every hold check
    a_err_no_spurious:
      assert property (@(posedge clk_sys) disable iff (!nrst)
        (!flag_stat_q[FLAG_W*ch+ERR_POS] && !chan_evt[ch].err)
        |=> !flag_stat_q[FLAG_W*ch+ERR_POS])
      else $error("error flag rose without an event");

    a_glob_flag_holds:
      assert property (@(posedge clk_sys) disable iff (!nrst)
        (flag_stat_q[FLAG_W*ch+GLOB_POS] && !clr_vec[FLAG_W*ch+GLOB_POS])
        |=> flag_stat_q[FLAG_W*ch+GLOB_POS])
      else $error("global flag dropped without a clear");

    // global clears nibble
    // Checked only without events, since a set wins over the clear
    a_glob_clears_nibble:
      assert property (@(posedge clk_sys) disable iff (!nrst)
        (clr_wr && reg_req.wdata[FLAG_W*ch+GLOB_POS] && chan_evt[ch] == '0)
        |=> flag_stat_q[FLAG_W*ch +: FLAG_W] == '0)
      else $error("global clear left a flag of a channel set");
  end

  a_event_sets_flag:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      chan_evt[0].err |=> flag_stat_q[ERR_POS] ##1
      (flag_stat_q[ERR_POS] || $past(clr_wr)))
    else $error("error flag not set or not held");

  a_global_on_event:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (chan_evt[CH_NUM-1] != '0) |=> flag_stat_q[TOP+GLOB_POS])
    else $error("global flag missed a channel event");

  a_strobe_one_cycle:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !clr_wr |=> clr_pulse_q == '0)
    else $error("clear strobe outlived its write");

  // Interrupt level tracks enabled flags
  a_irq_tracks_flags:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      irq_d |=> irq_q)
    else $error("interrupt missed an enabled flag");

  // ----------------------------------------------------------------
  // Interrupt, read path and strobe checks
  // ----------------------------------------------------------------
  // Interrupt falls once no enabled flag is set
  // A stuck level would keep software in its handler forever
  a_irq_falls_clear:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !irq_d |=> !irq_q)
    else $error("interrupt stayed high with no enabled flag");

  // Read data stand one cycle only
  // Holding the word longer would alias it onto the next read
  a_rd_idle_zero:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      !reg_req.rd |=> rd_data_q == REG_RST_VAL)
    else $error("read data present without a read");

  a_rd_clr_zero:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (reg_req.rd && hit_clr)
      |=> rd_data_q == REG_RST_VAL)
    else $error("clear register read back nonzero");

  // status read back
  // The word shows the flags as they stood at the read strobe
  a_rd_stat_value:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (reg_req.rd && hit_stat)
      |=> rd_data_q[FLAG_BITS-1:0] == $past(flag_stat_q))
    else $error("status read differs from the flags");

  // reserved bits ignored
  // Only with no event, so a set cannot mask a stray clear
  a_reserved_ignored:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      (clr_wr && reg_req.wdata[FLAG_BITS-1:0] == '0 && chan_evt == '0)
      |=> flag_stat_q == $past(flag_stat_q))
    else $error("write of reserved bits changed a flag");

  a_strobe_copies:
    assert property (@(posedge clk_sys) disable iff (!nrst)
      clr_wr
      |=> clr_pulse_q == $past(reg_req.wdata[FLAG_BITS-1:0]))
    else $error("clear strobe differs from the written word");

endmodule

// File: testbench/dma_flag_clear_tb.sv
// Self-checking bench for the DMA event-flag block and its clear register.
// Assumes dma_flag_pkg is compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module dma_flag_clear_tb
  import dma_flag_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                              clk_sys;      // 200 MHz clock
  logic                              nrst;         // Sync reset, active low
  reg_req_s                          req;          // Register request
  chan_evt_s [DEF_CH_NUM-1:0]        evt;          // Event pulses
  logic      [DATA_W-1:0]            rd_data;      // Read data
  logic      [FLAG_W*DEF_CH_NUM-1:0] stat;         // Sticky flags
  logic      [FLAG_W*DEF_CH_NUM-1:0] clr_pulse;    // Clear strobes
  logic                              irq;          // Interrupt level
  logic      [FLAG_W*DEF_CH_NUM-1:0] exp_stat;     // Expected flags
  logic      [DATA_W-1:0]            clr_word;     // Word being written
  int                                error_cnt;    // Mismatches
  int                                comparisons;  // Checks made

  dma_flag_clear #(.CH_NUM(DEF_CH_NUM)) i_dut (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .reg_req     (req),
    .chan_evt    (evt),
    .rd_data_q   (rd_data),
    .flag_stat_q (stat),
    .clr_pulse_q (clr_pulse),
    .irq_q       (irq)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare, count, report at once
  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    comparisons++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  // One-cycle write; sampled after the taking edge settles
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    #1;
  endtask

  // One-cycle read; data stands only in the next cycle
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] want, input string what);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    check(rd_data, want, what);
  endtask

  // One-cycle event pulse on the chosen channels
  task automatic fire(input logic [6:0] chans, input chan_evt_s e);
    @(posedge clk_sys);
    for (int i = 0; i < DEF_CH_NUM; i++) evt[i] <= chans[i] ? e : chan_evt_s'(3'h0);
    @(posedge clk_sys);
    evt <= '0;
    #1;
  endtask

  // Counts, verdict, stop
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Tests need under two hundred cycles; 5000 cycles means a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    error_cnt++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    req = '0;
    evt = '0;
    error_cnt = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    // Reset values and map
    reg_rd(FLAG_STAT_OFS, 32'h0000_0000, "status reset");
    reg_rd(IRQ_EN_OFS, 32'h0000_0000, "enable reset");
    reg_rd(FLAG_CLR_OFS, 32'h0000_0000, "clear reads zero");
    reg_rd(8'h10, 32'h0000_0000, "unmapped read");
    $display("test reset done");
    // Every flag of every channel set, then cleared one bit at a time
    fire(7'h7F, '{err: 1'b1, half: 1'b1, done: 1'b1});
    exp_stat = '1;
    check(stat, exp_stat, "all set");
    reg_wr(FLAG_CLR_OFS, 32'hF000_0000);
    check(stat, exp_stat, "reserved bits");
    check(clr_pulse, 28'h000_0000, "reserved strobes");
    for (int ch = 0; ch < DEF_CH_NUM; ch++) begin
      for (int b = 3; b >= 0; b--) begin
        clr_word = 32'h0000_0001 << (4 * ch + b);
        reg_wr(FLAG_CLR_OFS, clr_word);
        exp_stat[4 * ch + b] = 1'b0;
        check(clr_pulse, clr_word[27:0], "strobe");
        check(stat, exp_stat, "single clear");
      end
    end
    @(posedge clk_sys);
    #1;
    check(clr_pulse, 28'h000_0000, "strobe one cycle");
    $display("test single clears done");
    // Global bit clears all four; each event kind raises global
    fire(7'h7F, '{err: 1'b1, half: 1'b1, done: 1'b1});
    exp_stat = '1;
    for (int ch = 0; ch < DEF_CH_NUM; ch++) begin
      clr_word = 32'h0000_0001 << (4 * ch);
      reg_wr(FLAG_CLR_OFS, clr_word);
      exp_stat[4 * ch +: 4] = 4'h0;
      check(stat, exp_stat, "global clear");
      fire(7'h01 << ch, chan_evt_s'(3'h1 << (ch % 3)));
      exp_stat[4 * ch +: 4] = (4'h2 << (ch % 3)) | 4'h1;
      check(stat, exp_stat, "event sets global");
      reg_wr(FLAG_CLR_OFS, clr_word);
      exp_stat[4 * ch +: 4] = 4'h0;
    end
    check(stat, 28'h000_0000, "all cleared");
    $display("test global clears done");
    // Interrupt raised, masked and cleared
    reg_wr(IRQ_EN_OFS, 32'h0000_0001);
    reg_rd(IRQ_EN_OFS, 32'h0000_0001, "enable readback");
    fire(7'h02, '{err: 1'b0, half: 1'b0, done: 1'b1});
    @(posedge clk_sys);
    #1;
    check(irq, 1'b0, "masked channel");
    fire(7'h01, '{err: 1'b1, half: 1'b0, done: 1'b0});
    @(posedge clk_sys);
    #1;
    check(irq, 1'b1, "enabled channel");
    reg_rd(FLAG_STAT_OFS, 32'h0000_0039, "status read");
    @(posedge clk_sys);
    #1;
    check(rd_data, 32'h0000_0000, "read data one cycle");
    reg_wr(FLAG_CLR_OFS, 32'h0000_0001);
    @(posedge clk_sys);
    #1;
    check(irq, 1'b0, "irq after clear");
    reg_wr(IRQ_EN_OFS, 32'hFFFF_FFFF);
    reg_rd(IRQ_EN_OFS, 32'h0FFF_FFFF, "enable top bits");
    check(irq, 1'b1, "other channel");
    reg_wr(FLAG_CLR_OFS, 32'h0111_1111);
    @(posedge clk_sys);
    #1;
    check(irq, 1'b0, "all cleared irq");
    $display("test interrupt done");
    // Event beside its own clear in one cycle
    @(posedge clk_sys);
    evt[2] <= '{err: 1'b1, half: 1'b0, done: 1'b0};
    req <= '{addr: FLAG_CLR_OFS, wdata: 32'h0000_0800, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    evt <= '0;
    req.wr <= 1'b0;
    #1;
    check(stat[11:8], 4'h9, "set beats clear");
    $display("test set versus clear done");
    end_of_test();
  end

endmodule
